// ==== rtl/imd_pkg.sv ====
package imd_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [11:0] IDX_STATUS_MASK_TWO = 12'h739;
  localparam logic [11:0] IDX_OUTPUT_CONTROL = 12'h740;
  localparam logic [11:0] IDX_DEBOUNCE_CONTROL = 12'h748;
  localparam logic [11:0] IDX_EVENT_STATUS = 12'h750;
  localparam logic [11:0] IDX_RAW_STATUS = 12'h751;
  localparam int ADDR_W = 14;
  localparam int REG_W = 16;
  // Field positions
  localparam int BIT_MIC = 1;
  localparam int BIT_TSHUT = 0;
  localparam int BIT_GLOBAL = 0;
  localparam int BIT_TWARN = 5;
  // Reset values
  localparam logic [15:0] RST_STATUS_MASK_TWO = 16'h0003;
  localparam logic [15:0] RST_OUTPUT_CONTROL = 16'h0000;
  localparam logic [15:0] RST_DEBOUNCE_CONTROL = 16'h003f;
  // De-bounce time and its cycle count at 40 MHz
  localparam int DEBOUNCE_US = 100;
  localparam int CLOCK_MHZ = 40;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLOCK_MHZ;
  localparam int CNT_W = 13;
endpackage : imd_pkg

// ==== rtl/imd_debounce.sv ====
`timescale 1ns/1ps
`default_nettype none
module imd_debounce (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic enable,
  // Level from the synchroniser and its filtered copy
  input wire logic raw_in,
  output logic level_out
);
  logic [imd_pkg::CNT_W-1:0] count;

  // Output follows input on the next edge, or only after it has held steady
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      level_out <= 1'b0;
    end else if (!enable || raw_in == level_out) begin
      count <= '0;
      level_out <= raw_in;
    end else if (count == imd_pkg::CNT_W'(imd_pkg::DEBOUNCE_CYCLES - 1)) begin
      count <= '0;
      level_out <= raw_in;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : imd_debounce
`default_nettype wire

// ==== rtl/imd_irq_ctrl.sv ====
// Contract
// - Mask bit 1 of the second status mask register blocks the mic-detect interrupt when 1 and resets to 1.
// - Mask bit 0 of the second status mask register blocks the thermal-shutdown interrupt when 1, reset 1.
// - Bit 0 of the interrupt control register suppresses the interrupt output when 1 and resets to 0.
// - De-bounce control bits 5 and 0 enable de-bounce of thermal warning and shutdown, both reset to 1.
// - The raw thermal-shutdown flag is 1 above the shutdown level and 0 below, resetting to 0.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module imd_irq_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [imd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Asynchronous event pins
  input wire logic mic_detect_in,
  input wire logic thermal_shutdown_in,
  input wire logic thermal_warning_in,
  // Filtered thermal warning for the rest of the codec
  output logic thermal_warning_level,
  // Interrupt request to the host
  output logic irq
);
  logic [15:0] irq_status_mask_two;
  logic [15:0] irq_output_control;
  logic [15:0] irq_debounce_control;
  logic [1:0] event_status;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic thermal_shutdown_raw_flag;
  logic mic_level;
  logic [1:0] source_level;
  logic ack;
  logic [11:0] index;
  logic hit;
  logic sel_mask_two;
  logic sel_output_control;
  logic sel_debounce_control;
  logic sel_event_status;
  logic sel_raw_status;
  logic mic_pending;
  logic tshut_pending;
  logic wr_stb;
  logic [15:0] wdata;
  logic [15:0] next_rdata;
  logic [1:0] set_events;

  // Named control fields of the configuration registers
  wire mic_detect_irq_mask = irq_status_mask_two[imd_pkg::BIT_MIC];
  wire thermal_shutdown_irq_mask = irq_status_mask_two[imd_pkg::BIT_TSHUT];
  wire irq_output_global_mask = irq_output_control[imd_pkg::BIT_GLOBAL];
  wire thermal_warning_debounce_en = irq_debounce_control[imd_pkg::BIT_TWARN];
  wire thermal_shutdown_debounce_en = irq_debounce_control[imd_pkg::BIT_TSHUT];

  // Two-stage synchronisers for the pins; only the second stage is read,
  // so a metastable first stage never reaches the decode or the filters,
  // and every pin sees the same two cycles of delay
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {thermal_warning_in, thermal_shutdown_in, mic_detect_in};
      sync_b <= sync_a;
    end
  end

  // Microphone detect is synchronised only, never filtered
  assign mic_level = sync_b[0];

  // Optional de-bounce on the thermal sources; a disabled filter passes the
  // synchronised level on with one register of delay, so event timing only
  // grows by the filter time when de-bounce is enabled
  imd_debounce u_db_tshut (
    .clock(clock),
    .resetn(resetn),
    .enable(thermal_shutdown_debounce_en),
    .raw_in(sync_b[1]),
    .level_out(thermal_shutdown_raw_flag)
  );

  // Filtered warning level leaves the block; it raises no interrupt here
  imd_debounce u_db_twarn (
    .clock(clock),
    .resetn(resetn),
    .enable(thermal_warning_debounce_en),
    .raw_in(sync_b[2]),
    .level_out(thermal_warning_level)
  );

  // Levels whose rising edges raise the sticky event bits
  assign source_level[imd_pkg::BIT_MIC] = mic_level;
  assign source_level[imd_pkg::BIT_TSHUT] = thermal_shutdown_raw_flag;

  // One rising-edge detector per source; the history resets to the idle low
  // level of the pins, so releasing reset cannot fake an event
  genvar src;
  generate
    for (src = 0; src < $bits(set_events); src++) begin : g_edge
      logic prev;
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          prev <= 1'b0;
        end else begin
          prev <= source_level[src];
        end
      end
      assign set_events[src] = source_level[src] & ~prev;
    end
  endgenerate

  // Word index and register selects
  assign index = avs_address[imd_pkg::ADDR_W-1:2];
  assign sel_mask_two = (index == imd_pkg::IDX_STATUS_MASK_TWO);
  assign sel_output_control = (index == imd_pkg::IDX_OUTPUT_CONTROL);
  assign sel_debounce_control = (index == imd_pkg::IDX_DEBOUNCE_CONTROL);
  assign sel_event_status = (index == imd_pkg::IDX_EVENT_STATUS);
  assign sel_raw_status = (index == imd_pkg::IDX_RAW_STATUS);
  assign hit = sel_mask_two | sel_output_control | sel_debounce_control | sel_event_status | sel_raw_status;

  // One wait cycle per access: waitrequest drops in the cycle after the request
  // is first seen, and the write strobe fires on the edge that samples it low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_stb = avs_write & ack;
  assign wdata = avs_writedata[15:0];

  // Write mask honouring the two low byte lanes; the upper lanes carry
  // no register bits, since every register here is sixteen bits wide
  function automatic logic [15:0] imd_merge(input logic [15:0] old, input logic [15:0] val, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = val[7:0];
    if (be[1]) r[15:8] = val[15:8];
    return r;
  endfunction : imd_merge

  // Acknowledge one cycle after the request is seen, cleared on the answering
  // edge so that back-to-back requests each get their own wait cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) ack <= 1'b0;
    else ack <= (avs_read | avs_write) & ~ack;
  end

  // Configuration registers; reserved bits are kept exactly as written, so
  // software that keeps them at their reset value reads that value back
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status_mask_two <= imd_pkg::RST_STATUS_MASK_TWO;
      irq_output_control <= imd_pkg::RST_OUTPUT_CONTROL;
      irq_debounce_control <= imd_pkg::RST_DEBOUNCE_CONTROL;
    end else if (wr_stb) begin
      if (sel_mask_two) begin
        irq_status_mask_two <= imd_merge(irq_status_mask_two, wdata, avs_byteenable);
      end
      if (sel_output_control) begin
        irq_output_control <= imd_merge(irq_output_control, wdata, avs_byteenable);
      end
      if (sel_debounce_control) begin
        irq_debounce_control <= imd_merge(irq_debounce_control, wdata, avs_byteenable);
      end
    end
  end

  // Sticky event bits, write one to clear; an event in the clearing cycle
  // survives the clear, so no edge is lost to a late acknowledge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_status <= 2'h0;
    end else if (wr_stb && sel_event_status && avs_byteenable[0]) begin
      event_status <= (event_status & ~wdata[1:0]) | set_events;
    end else begin
      event_status <= event_status | set_events;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 16'h0000;
    case (index)
      imd_pkg::IDX_STATUS_MASK_TWO: next_rdata = irq_status_mask_two;
      imd_pkg::IDX_OUTPUT_CONTROL: next_rdata = irq_output_control;
      imd_pkg::IDX_DEBOUNCE_CONTROL: next_rdata = irq_debounce_control;
      imd_pkg::IDX_EVENT_STATUS: next_rdata = {14'h0000, event_status};
      imd_pkg::IDX_RAW_STATUS: next_rdata = {14'h0000, mic_level, thermal_shutdown_raw_flag};
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data and response, loaded on the first edge of a request and held
  // until the next request, so the master may take them on its sample edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if ((avs_read | avs_write) && !ack) begin
      avs_readdata <= {16'h0000, next_rdata};
      avs_response <= hit ? 2'h0 : 2'h3;
    end
  end

  // Per-source pending terms behind their own masks
  assign mic_pending = event_status[imd_pkg::BIT_MIC] & ~mic_detect_irq_mask;
  assign tshut_pending = event_status[imd_pkg::BIT_TSHUT] & ~thermal_shutdown_irq_mask;

  // Interrupt output, registered so that the host sees a glitch-free level
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= ~irq_output_global_mask & (mic_pending | tshut_pending);
    end
  end
endmodule : imd_irq_ctrl
`default_nettype wire

// ==== bench/imd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module imd_host_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Request line and the host's late view of it
  input wire logic irq,
  output logic irq_seen
);
  logic [LAT-1:0] dly;
  // Host notices the request some cycles late
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) dly <= '0;
    else dly <= {dly[LAT-2:0], irq};
  end
  assign irq_seen = dly[LAT-1];
endmodule : imd_host_model
`default_nettype wire

// ==== bench/imd_irq_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module imd_irq_props (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Bus and pins
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mic_detect_in,
  input wire logic irq
);
  logic [1:0] ms;
  logic [1:0] ds;
  logic gs;
  wire logic [11:0] ix = avs_address[13:2];
  wire logic rd = avs_read && !avs_waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Shadow mask and de-bounce enable bits from completed writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ms <= 2'h3;
      ds <= 2'h3;
      gs <= 1'b0;
    end else if (avs_write && !avs_waitrequest) begin
      if (ix == 12'h739) ms <= avs_writedata[1:0];
      if (ix == 12'h740) gs <= avs_writedata[0];
      if (ix == 12'h748) ds <= {avs_writedata[5], avs_writedata[0]};
    end
  end
  mask_read_a: assert property (
    rd && ix == 12'h739 |-> avs_readdata[1:0] == ms) else $error("mask readback wrong");
  ctrl_read_a: assert property (
    rd && ix == 12'h740 |-> avs_readdata[0] == gs) else $error("control readback wrong");
  deb_read_a: assert property (
    rd && ix == 12'h748 |-> {avs_readdata[5], avs_readdata[0]} == ds) else $error("filter readback wrong");
  glob_block_a: assert property (
    irq |-> !$past(gs)) else $error("irq despite global mask");
  mask_block_a: assert property (
    irq |-> $past(ms) != 2'h3) else $error("irq with all sources masked");
  mic_irq_a: assert property (
    $rose(mic_detect_in) && !ms[1] && !gs |-> ##[1:8] irq) else $error("irq missing");
  cover property (rd);
  cover property ($rose(irq));
  cover property ($fell(irq) && gs);
endmodule : imd_irq_props
bind imd_irq_ctrl imd_irq_props u_props (.clock(clock), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .mic_detect_in(mic_detect_in), .irq(irq));
`default_nettype wire

// ==== bench/imd_irq_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module imd_irq_ctrl_tb_top;
  logic clock, resetn, rd, wr, mic, tsh, twn, irq, seen, twl, wrq;
  logic [13:0] adr;
  logic [31:0] wd, rdat, r;
  logic [3:0] be;
  logic [1:0] rsp;
  logic [15:0] eq[$], mq[$];
  integer mismatches, tests_run, seed;
  imd_irq_ctrl dut (.clock(clock), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq), .avs_response(rsp),
    .mic_detect_in(mic), .thermal_shutdown_in(tsh), .thermal_warning_in(twn), .thermal_warning_level(twl), .irq(irq));
  imd_host_model #(.LAT(3)) host (.clock(clock), .resetn(resetn), .irq(irq), .irq_seen(seen));
  task check(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task bus(input logic w, input logic [11:0] ix, input logic [15:0] d, m);
    integer k;
    @(posedge clock);
    adr <= {ix, 2'h0};
    rd <= !w;
    wr <= w;
    wd <= {16'h0, d};
    be <= 4'h3;
    if (!w) eq.push_back(d);
    if (!w) mq.push_back(m);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wrq !== 1'b0 && k < 50);
    if (wrq !== 1'b0) begin
      mismatches++;
      summarize;
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task wirq(input logic v);
    integer k;
    for (k = 0; k < 20 && seen !== v; k++) @(posedge clock);
    check("irq", {31'h0, seen}, {31'h0, v});
  endtask : wirq
  // Clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Read results are compared as they appear
  always @(posedge clock) begin
    if (rd && wrq === 1'b0) begin
      check("readdata", {16'h0, rdat[15:0] & mq.pop_front()}, {16'h0, eq.pop_front()});
    end
  end
  // Main sequence
  initial begin
    {resetn, rd, wr, mic, tsh, twn, adr, wd, be, mismatches, tests_run} = '0;
    seed = 48;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, 12'h739, 16'h0003, 16'h0003);
    check("response", {30'h0, rsp}, 32'h0);
    bus(1'b0, 12'h740, 16'h0000, 16'h0001);
    bus(1'b0, 12'h748, 16'h0021, 16'h0021);
    bus(1'b0, 12'h751, 16'h0000, 16'h0001);
    bus(1'b0, 12'h100, 16'h0000, 16'hffff);
    check("response", {30'h0, rsp}, 32'h3);
    r = $random(seed);
    bus(1'b1, 12'h739, {r[15:2], 2'h1}, 16'h0000);
    mic <= 1'b1;
    wirq(1'b1);
    bus(1'b0, 12'h750, 16'h0002, 16'h0003);
    bus(1'b1, 12'h740, 16'h0001, 16'h0000);
    wirq(1'b0);
    bus(1'b1, 12'h740, 16'h0000, 16'h0000);
    wirq(1'b1);
    bus(1'b1, 12'h739, 16'h0003, 16'h0000);
    wirq(1'b0);
    mic <= 1'b0;
    bus(1'b1, 12'h750, 16'h0003, 16'h0000);
    bus(1'b0, 12'h750, 16'h0000, 16'h0003);
    twn <= 1'b1;
    repeat (50) @(posedge clock);
    check("warn", {31'h0, twl}, 32'h0);
    repeat (4000) @(posedge clock);
    check("warn", {31'h0, twl}, 32'h1);
    bus(1'b1, 12'h748, 16'h001e, 16'h0000);
    twn <= 1'b0;
    bus(1'b1, 12'h739, 16'h0002, 16'h0000);
    tsh <= 1'b1;
    wirq(1'b1);
    check("warn", {31'h0, twl}, 32'h0);
    bus(1'b0, 12'h751, 16'h0001, 16'h0001);
    bus(1'b1, 12'h739, 16'h0003, 16'h0000);
    wirq(1'b0);
    summarize;
  end
endmodule : imd_irq_ctrl_tb_top
`default_nettype wire
